// *** pkg/iac_params.svh ***
// Offsets, field positions, reset values and timing counts of the address block
`ifndef IAC_PARAMS_SVH
`define IAC_PARAMS_SVH
// Register byte offsets
`define IAC_OFF_CTRL      12'h000
`define IAC_OFF_DEST      12'h004
`define IAC_OFF_OWN       12'h008
`define IAC_OFF_CMD       12'h010
`define IAC_OFF_MASK      12'h030
`define IAC_OFF_STAT      12'h034
`define IAC_OFF_STATE     12'h070
// Control register fields
`define IAC_CTL_ON        0
`define IAC_CTL_SWIDE     3
`define IAC_CTL_MWIDE     4
`define IAC_CTL_RSA       5
// Destination register fields
`define IAC_DST_MWIDE     12
`define IAC_DST_ALT       11
`define IAC_DST_BOS       10
// Command register field
`define IAC_CMD_RD        8
// Status and mask fields
`define IAC_IRQ_MATCH     2
`define IAC_IRQ_RDREQ     5
`define IAC_IRQ_ABORT     6
`define IAC_IRQ_DONE      9
// Reset values
`define IAC_RST_ADDR      10'h055
`define IAC_RST_RSA       1'b1
// Bus byte values
`define IAC_BCAST_BYTE    8'h00
`define IAC_SBYTE_BYTE    8'h01
`define IAC_HDR10_TAG     5'h1e
// Timing
`define IAC_CLK_NS        8
`define IAC_SCL_HALF_NS   32
`define IAC_SCL_HALF_CYC  ((`IAC_SCL_HALF_NS + `IAC_CLK_NS - 1) / `IAC_CLK_NS)
`endif

// *** pkg/iac_pkg.sv ***
// Types shared by the address control block
package iac_pkg;
  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } iac_apb_req_t;
  // APB answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } iac_apb_rsp_t;
  // Bytes of one master frame, byte 0 first
  typedef struct packed {
    logic [1:0]  nbytes;
    logic [23:0] bytes;
  } iac_frame_t;
  // Master sequencer states
  typedef enum logic [2:0] {MS_IDLE, MS_STRT, MS_LOW, MS_HIGH, MS_STOP} iac_mst_state_t;
endpackage

// *** src/iac_addr_ctrl.sv ***
// Address control of the I2C block: APB registers, command decode, pins
//
// Notes on behaviour
// - Master wide bit selects 10- or 7-bit
// - Wide bit exists only with runtime update
// - Alt command bit enables bit-ten command
// - Bit ten chooses START byte or broadcast
// - Read after broadcast raises transmit abort
// - Broadcast mode holds until alt bit cleared or bit ten set
// - Target field addresses every 7- and 10-bit master transfer
// - Broadcast ignores the target field
// - Slave never answers its own master; simplex loopback
// - Slave matches own bits 6:0 in 7-bit
// - Own address writable only while disabled
// - Own change re-raises read request on enable
// - No repeat start: START byte, wide read abort
// - Slave wide select picks address format
`timescale 1ns/1ns
`include "iac_params.svh"
module iac_addr_ctrl #(
  parameter bit DYN_TAR = 1'b1,              // Runtime destination update option
  parameter int HALF    = `IAC_SCL_HALF_CYC  // SCL half period in clocks
) (
  // System
  input  wire logic                  clk,
  input  wire logic                  reset,
  // APB slave
  input  wire iac_pkg::iac_apb_req_t apb_req,
  output      iac_pkg::iac_apb_rsp_t apb_rsp,
  // Interrupt
  output      logic                  irq,
  // I2C pins, open drain
  input  wire logic                  scl_i,
  output      logic                  scl_o,
  output      logic                  scl_oe_n,
  input  wire logic                  sda_i,
  output      logic                  sda_o,
  output      logic                  sda_oe_n
);
  import iac_pkg::*;
  // Below three clocks the registered SDA would move with the SCL rise
  initial if (HALF < 3 || HALF > 20000) $error("iac_addr_ctrl: HALF out of range");

  // Control register
  logic       on;         // Interface enable
  logic       swide;      // Slave wide address select
  logic       mwide_ctl;  // Master wide bit, used without runtime update
  logic       rsa;        // Repeat start allowed
  // Destination register
  logic [9:0] dest;       // Target address field
  logic       bos;        // Broadcast or START byte
  logic       alt_cmd;    // Alternate command select
  logic       mwide_dst;  // Master wide select in destination
  // Own address and interrupt state
  logic [9:0] own;        // Own address field
  logic [9:0] stat;       // Unmasked status, sticky
  logic [9:0] mask;       // Interrupt mask
  logic       on_q;       // Enable, one clock late
  logic       rd_pend;    // Own changed while read request set
  logic [31:0] prdata;    // Registered read data
  logic        m_sda_oe_n, s_sda_oe_n, m_busy, m_done, s_match, s_rd;

  // Address compare used by every decoder
  function automatic logic is_reg(input logic [11:0] adr, input logic [11:0] off);
    return adr == off;
  endfunction
  // First byte of a 10-bit address
  function automatic logic [7:0] hdr10(input logic [1:0] hi, input logic rd);
    return {`IAC_HDR10_TAG, hi, rd};
  endfunction

  // APB decode
  wire [11:0] adr  = apb_req.paddr;
  wire [31:0] wd   = apb_req.pwdata;
  wire        acc  = apb_req.psel & apb_req.penable;
  wire        wr   = acc & apb_req.pwrite;
  wire        h_ctl = is_reg(adr, `IAC_OFF_CTRL);
  wire        h_dst = is_reg(adr, `IAC_OFF_DEST);
  wire        h_own = is_reg(adr, `IAC_OFF_OWN);
  wire        h_cmd = is_reg(adr, `IAC_OFF_CMD);
  wire        h_msk = is_reg(adr, `IAC_OFF_MASK);
  wire        h_sta = is_reg(adr, `IAC_OFF_STAT);
  wire        h_stt = is_reg(adr, `IAC_OFF_STATE);
  wire        hit  = h_ctl | h_dst | h_own | h_cmd | h_msk | h_sta | h_stt;
  wire        own_we = wr & h_own & ~on;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = acc & ~hit;
  assign apb_rsp.prdata  = prdata;

  // Master addressing mode and command decode
  wire mwide  = DYN_TAR ? mwide_dst : mwide_ctl;
  wire bcast  = alt_cmd & ~bos;
  wire sbyte  = alt_cmd & bos;
  wire cmd_rd = wd[`IAC_CMD_RD];
  wire cmd_ok = wr & h_cmd & on & ~m_busy;
  wire ab_gc  = bcast & cmd_rd;
  wire ab_rs  = ~rsa & (sbyte | (~alt_cmd & mwide & cmd_rd));
  wire abort  = cmd_ok & (ab_gc | ab_rs);
  wire go     = cmd_ok & ~abort;
  iac_frame_t frame;
  // One byte for broadcast, START byte and 7-bit; two or three for 10-bit
  assign frame.nbytes = (alt_cmd | ~mwide) ? 2'd1 : (cmd_rd ? 2'd3 : 2'd2);
  assign frame.bytes  =
      bcast  ? {16'h0000, `IAC_BCAST_BYTE} :
      sbyte  ? {16'h0000, `IAC_SBYTE_BYTE} :
      ~mwide ? {16'h0000, dest[6:0], cmd_rd} :
               {hdr10(dest[9:8], 1'b1), dest[7:0], hdr10(dest[9:8], 1'b0)};

  // Events into the sticky status
  wire reload = on & ~on_q & rd_pend;
  wire [9:0] ev = (10'(abort) << `IAC_IRQ_ABORT)
                | (10'((s_match & s_rd) | reload) << `IAC_IRQ_RDREQ)
                | (10'(s_match & ~s_rd) << `IAC_IRQ_MATCH)
                | (10'(m_done) << `IAC_IRQ_DONE);
  wire [9:0] clr = (wr & h_sta) ? wd[9:0] : 10'h000;
  assign irq = |(stat & mask);

  // Read data words
  wire [31:0] w_ctl = (32'(on) << `IAC_CTL_ON) | (32'(swide) << `IAC_CTL_SWIDE)
                    | (32'(mwide_ctl) << `IAC_CTL_MWIDE) | (32'(rsa) << `IAC_CTL_RSA);
  wire [31:0] w_dst = (32'(mwide_dst) << `IAC_DST_MWIDE) | (32'(alt_cmd) << `IAC_DST_ALT)
                    | (32'(bos) << `IAC_DST_BOS) | {22'h00_0000, dest};
  wire [31:0] w_rd  = h_ctl ? w_ctl :
                      h_dst ? w_dst :
                      h_own ? {22'h00_0000, own} :
                      h_msk ? {22'h00_0000, mask} :
                      h_sta ? {22'h00_0000, stat} :
                      h_stt ? {30'h0000_0000, bcast, m_busy} : 32'h0000_0000;

  // Control register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      on <= 1'b0; swide <= 1'b0; mwide_ctl <= 1'b0; rsa <= `IAC_RST_RSA;
    end else if (wr && h_ctl) begin
      on <= wd[`IAC_CTL_ON]; swide <= wd[`IAC_CTL_SWIDE];
      mwide_ctl <= wd[`IAC_CTL_MWIDE]; rsa <= wd[`IAC_CTL_RSA];
    end
  end

  // Destination register; the wide bit is absent without runtime update
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dest <= `IAC_RST_ADDR; bos <= 1'b0; alt_cmd <= 1'b0; mwide_dst <= 1'b0;
    end else if (wr && h_dst) begin
      dest <= wd[9:0]; bos <= wd[`IAC_DST_BOS]; alt_cmd <= wd[`IAC_DST_ALT];
      mwide_dst <= DYN_TAR & wd[`IAC_DST_MWIDE];
    end
  end

  // Own address, held while the interface is enabled
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      own <= `IAC_RST_ADDR;
    end else if (own_we) begin
      own <= wd[9:0];
    end
  end

  // Status, mask and the read-request reload
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stat <= '0; mask <= '0; on_q <= 1'b0; rd_pend <= 1'b0;
    end else begin
      stat <= (stat & ~clr) | ev;
      on_q <= on;
      if (wr && h_msk) mask <= wd[9:0];
      if (reload) rd_pend <= 1'b0;
      else if (own_we && wd[9:0] != own && stat[`IAC_IRQ_RDREQ]) rd_pend <= 1'b1;
    end
  end

  // Read data and pin enables from flip-flops
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata <= '0; sda_oe_n <= 1'b1;
    end else begin
      if (apb_req.psel && !apb_req.penable) prdata <= w_rd;
      sda_oe_n <= m_sda_oe_n & s_sda_oe_n;
    end
  end
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  // Master sequencer
  iac_mstr #(.HALF(HALF)) u_mstr (
    .clk      (clk),
    .reset    (reset),
    .go       (go),
    .frame    (frame),
    .busy     (m_busy),
    .done     (m_done),
    .scl_oe_n (scl_oe_n),
    .sda_oe_n (m_sda_oe_n)
  );

  // Slave matcher, blind while the master drives so it never answers itself
  wire s_en = on & ~m_busy;
  iac_slv u_slv (
    .clk      (clk),
    .reset    (reset),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .own      (own),
    .swide    (swide),
    .enable   (s_en),
    .match    (s_match),
    .match_rd (s_rd),
    .sda_oe_n (s_sda_oe_n)
  );

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire cmd_wr_on = wr & h_cmd & on & ~m_busy;
  a_own_write_locked: assert property (wr && h_own && on |=> $stable(own))
    else $error("own address changed while enabled");
  a_bcast_read_abort: assert property (cmd_wr_on && bcast && cmd_rd
    |=> stat[`IAC_IRQ_ABORT] && !m_busy) else $error("broadcast read not aborted");
  a_norsa_sbyte_abort: assert property (cmd_wr_on && sbyte && !rsa
    |=> stat[`IAC_IRQ_ABORT] && !m_busy) else $error("START byte without restart");
  a_bcast_byte_zero: assert property (go && bcast
    |-> frame.bytes[7:0] == 8'h00 && frame.nbytes == 2'd1) else $error("bad broadcast");
  a_sbyte_value: assert property (go && sbyte
    |-> (frame.bytes[7:0] == `IAC_SBYTE_BYTE) ##1 m_busy) else $error("START byte not sent");
  a_seven_bit_byte: assert property (go && !alt_cmd && !mwide
    |-> frame.bytes[7:0] == {dest[6:0], cmd_rd}) else $error("bad 7-bit byte");
  a_ten_bit_hdr: assert property (go && !alt_cmd && mwide
    |-> frame.bytes[7:3] == 5'h1e && frame.bytes[15:8] == dest[7:0])
    else $error("bad 10-bit header");
  a_loop_blind: assert property (m_busy |-> !s_en)
    else $error("slave listens to own master");
  a_rdreq_reload: assert property ($rose(on) && rd_pend
    |=> stat[`IAC_IRQ_RDREQ] && !rd_pend) else $error("read request not re-raised");
  a_wide_absent: assert property (!DYN_TAR |-> !mwide_dst)
    else $error("wide bit present without runtime update");
  c_bcast_sent: cover property (go && bcast ##[1:400] m_done);
  c_ten_read: cover property (go && mwide && cmd_rd && !alt_cmd);
  c_slave_match: cover property (s_match);
  c_abort_seen: cover property (abort);
endmodule

// *** src/iac_mstr.sv ***
// Master sequencer: START, address bytes with released ACK slot, STOP
`timescale 1ns/1ns
module iac_mstr #(
  parameter int HALF = 4  // SCL half period in clocks
) (
  // System
  input  wire logic               clk,
  input  wire logic               reset,
  // Request
  input  wire logic               go,
  input  wire iac_pkg::iac_frame_t frame,
  output      logic               busy,
  output      logic               done,
  // Pins, open drain
  output      logic               scl_oe_n,
  output      logic               sda_oe_n
);
  import iac_pkg::*;
  // SDA moves a clock into the low phase and the pin register adds one more,
  // so a half period of two would let SDA change on the SCL rise
  initial if (HALF < 3 || HALF > 20000) $error("iac_mstr: HALF out of range");
  iac_mst_state_t   st;      // Sequencer state
  iac_frame_t       fr;      // Captured frame
  logic [15:0]      cnt;     // Phase timer
  logic [3:0]       bitn;    // Bit in byte, 8 is the ACK slot
  logic [1:0]       byten;   // Byte in frame
  wire  [15:0]      half = 16'(HALF);
  wire              t_end = cnt == half - 16'h0001;
  wire  [7:0]       cur = fr.bytes[8*byten +: 8];
  assign busy = st != MS_IDLE;
  // Sequencer; the bus is not read back, so no arbitration is done
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= MS_IDLE; fr <= '0; cnt <= '0; bitn <= '0; byten <= '0;
      done <= 1'b0; scl_oe_n <= 1'b1; sda_oe_n <= 1'b1;
    end else begin
      done <= 1'b0;
      cnt  <= cnt + 16'h0001;
      case (st)
        MS_IDLE: begin
          cnt <= '0;
          if (go) begin
            // START: SDA falls while SCL is high
            fr <= frame; sda_oe_n <= 1'b0; st <= MS_STRT;
          end
        end
        MS_STRT: if (t_end) begin
          scl_oe_n <= 1'b0; bitn <= '0; byten <= '0; cnt <= '0; st <= MS_LOW;
        end
        MS_LOW: begin
          // Data changes only while SCL is low; ACK slot is released
          if (cnt == 16'h0000) sda_oe_n <= (bitn == 4'd8) ? 1'b1 : cur[3'(7 - bitn)];
          if (t_end) begin
            scl_oe_n <= 1'b1; cnt <= '0; st <= MS_HIGH;
          end
        end
        MS_HIGH: if (t_end) begin
          scl_oe_n <= 1'b0; cnt <= '0;
          if (bitn != 4'd8) begin
            bitn <= bitn + 4'd1; st <= MS_LOW;
          end else if (byten == fr.nbytes - 2'd1) begin
            st <= MS_STOP;
          end else begin
            bitn <= '0; byten <= byten + 2'd1; st <= MS_LOW;
          end
        end
        MS_STOP: begin
          // Low SDA, release SCL, then release SDA
          if (cnt == 16'h0000) sda_oe_n <= 1'b0;
          if (cnt == half) scl_oe_n <= 1'b1;
          if (cnt == 16'(2 * HALF)) begin
            sda_oe_n <= 1'b1; done <= 1'b1; st <= MS_IDLE;
          end
        end
        default: st <= MS_IDLE;
      endcase
    end
  end
endmodule

// *** src/iac_slv.sv ***
// Slave address matcher on sampled SCL and SDA, with address ACK
`timescale 1ns/1ns
`include "iac_params.svh"
module iac_slv (
  // System
  input  wire logic       clk,
  input  wire logic       reset,
  // Pins and settings
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [9:0] own,
  input  wire logic       swide,
  input  wire logic       enable,
  // Result
  output      logic       match,
  output      logic       match_rd,
  output      logic       sda_oe_n
);
  logic [1:0] scl_sy, sda_sy;  // Two-stage synchronisers
  logic       scl_q, sda_q;    // Previous synchronised values
  logic [6:0] shf;             // Shift register
  logic [3:0] bitn;            // Bits taken in this byte
  logic       active;          // Frame is still addressing
  logic       second;          // Next byte is the low 10-bit address
  logic       ten_ok;          // Addressed by full 10-bit write
  logic       ack_pend;        // Drive ACK at next SCL fall
  wire scl_s = scl_sy[1];
  wire sda_s = sda_sy[1];
  wire rise  = scl_s & ~scl_q;
  wire fall  = ~scl_s & scl_q;
  wire start = scl_s & scl_q & sda_q & ~sda_s;
  wire stop  = scl_s & scl_q & ~sda_q & sda_s;
  wire [7:0] b = {shf, sda_s};
  wire last = rise & active & (bitn == 4'd7);
  // Byte checks: 7-bit on low seven bits, 10-bit header and low byte
  wire hit7  = ~swide & (b[7:1] == own[6:0]);
  wire hdr   = swide & (b[7:3] == `IAC_HDR10_TAG) & (b[2:1] == own[9:8]);
  wire hit_w = hdr & ~b[0];
  wire hit_r = hdr & b[0] & ten_ok;
  wire hit_l = b == own[7:0];
  // Synchronisers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_sy <= 2'b11; sda_sy <= 2'b11; scl_q <= 1'b1; sda_q <= 1'b1;
    end else begin
      scl_sy <= {scl_sy[0], scl_i}; sda_sy <= {sda_sy[0], sda_i};
      scl_q <= scl_s; sda_q <= sda_s;
    end
  end
  // Address phase tracking
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shf <= '0; bitn <= '0; active <= 1'b0; second <= 1'b0; ten_ok <= 1'b0;
      ack_pend <= 1'b0; match <= 1'b0; match_rd <= 1'b0; sda_oe_n <= 1'b1;
    end else begin
      match <= 1'b0;
      if (!enable || stop) begin
        active <= 1'b0; second <= 1'b0; ten_ok <= 1'b0; ack_pend <= 1'b0; sda_oe_n <= 1'b1;
      end else if (start) begin
        active <= 1'b1; bitn <= '0; second <= 1'b0;
      end else begin
        if (rise && active) begin
          shf <= b[6:0];
          bitn <= (bitn == 4'd8) ? 4'd0 : bitn + 4'd1;
        end
        if (last) begin
          // Only a byte that matches is acknowledged
          if (second) begin
            ack_pend <= hit_l; match <= hit_l; ten_ok <= hit_l;
            match_rd <= 1'b0; active <= 1'b0;
          end else begin
            ack_pend <= hit7 | hit_w | hit_r;
            match    <= hit7 | hit_r;
            match_rd <= b[0];
            second   <= hit_w;
            active   <= hit_w;
          end
        end
        if (fall) begin
          sda_oe_n <= ~ack_pend; ack_pend <= 1'b0;
        end
      end
    end
  end
endmodule

// *** tb/iac_bus_peer.sv ***
// Bus peer: an outside master that addresses the block, and a recorder of wire bytes
`timescale 1ns/1ns
module iac_bus_peer (
  // Wire levels
  input  wire logic scl,
  input  wire logic sda,
  // Peer drive, low pulls the line
  output      logic scl_oe_n,
  output      logic sda_oe_n
);
  logic [7:0] sh;       // Recorder shift register
  int         nbit;     // Bits since START or the last ACK slot
  logic [7:0] seen[$];  // Bytes seen on the wire
  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
    nbit     = 0;
    sh       = 8'h00;
  end
  // START restarts byte framing
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      nbit = 0;
    end
  end
  // Bits on SCL rise; the ninth slot is the ACK and closes the byte
  always @(posedge scl) begin
    if (nbit < 8) begin
      sh = {sh[6:0], sda};
    end
    nbit = nbit + 1;
    if (nbit == 9) begin
      seen.push_back(sh);
      nbit = 0;
    end
  end
  // START, n bytes with released ACK slots, STOP; acks bit i low when byte i was acked
  task automatic xfer(input int n, input logic [15:0] b, output logic [1:0] acks);
    int         i;
    int         k;
    logic [7:0] by;
    acks = 2'b11;
    sda_oe_n = 1'b0;
    #32;
    for (i = 0; i < n; i++) begin
      by = (i == 0) ? b[15:8] : b[7:0];
      for (k = 7; k >= -1; k--) begin
        scl_oe_n = 1'b0;
        #8;
        sda_oe_n = (k < 0) ? 1'b1 : by[k];
        #24;
        scl_oe_n = 1'b1;
        #16;
        if (k < 0) begin
          acks[i] = sda;
        end
        #16;
      end
    end
    // STOP: SDA rises while SCL is high
    scl_oe_n = 1'b0;
    #8;
    sda_oe_n = 1'b0;
    #24;
    scl_oe_n = 1'b1;
    #32;
    sda_oe_n = 1'b1;
    #32;
  endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench of the address control block
`timescale 1ns/1ns
`include "iac_params.svh"
module tb;
  import iac_pkg::*;
  logic         clk;         // System clock
  logic         reset;       // Reset, active high
  iac_apb_req_t req;         // APB request
  iac_apb_rsp_t rsp;         // APB answer
  logic         irq;         // Interrupt
  logic         scl_oe_n;    // Block pulls SCL
  logic         sda_oe_n;    // Block pulls SDA
  logic         p_scl_oe_n;  // Peer pulls SCL
  logic         p_sda_oe_n;  // Peer pulls SDA
  wire          scl = scl_oe_n & p_scl_oe_n;  // Pulled-up wire
  wire          sda = sda_oe_n & p_sda_oe_n;  // Pulled-up wire
  int           errors;      // Mismatches
  int           n_compared;  // Comparisons
  logic [31:0]  rd;          // Last read data
  logic         err;         // Last slave error
  logic [1:0]   acks;        // Peer ACK slots
  iac_addr_ctrl #(.DYN_TAR(1'b1), .HALF(3)) iac_addr_ctrl_inst (
    .clk(clk), .reset(reset), .apb_req(req), .apb_rsp(rsp), .irq(irq),
    .scl_i(scl), .scl_o(), .scl_oe_n(scl_oe_n),
    .sda_i(sda), .sda_o(), .sda_oe_n(sda_oe_n));
  iac_bus_peer iac_bus_peer_inst (
    .scl(scl), .sda(sda), .scl_oe_n(p_scl_oe_n), .sda_oe_n(p_sda_oe_n));
  // Verdict and end of run
  task automatic close_out;
    if (errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One comparison
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; an idle edge first keeps drives one per time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (rsp.pready === 1'b1) begin
        break;
      end
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    if (i == 50) begin
      chk("pready", 1, 0);
      close_out();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask
  // Master frame: bytes on the wire and status afterwards
  task automatic m_frame(input logic [31:0] dst, input logic r, input int n, input logic [23:0] e);
    int i;
    wr(`IAC_OFF_DEST, dst);
    iac_bus_peer_inst.seen.delete();
    wr(`IAC_OFF_CMD, {23'h0, r, 8'h00});
    for (i = 0; i < 400; i++) begin
      apb(1'b0, `IAC_OFF_STAT, 32'h0000_0000);
      if (rd[`IAC_IRQ_DONE] === 1'b1) begin
        break;
      end
    end
    if (i == 400) begin
      chk("frame done", 32'h0000_0001, 32'h0000_0000);
      close_out();
    end
    chk("status after frame", 32'h0000_0200, rd);
    chk("byte count", n, iac_bus_peer_inst.seen.size());
    for (i = 0; i < n && i < iac_bus_peer_inst.seen.size(); i++) begin
      chk("wire byte", {24'h0, e[23-8*i -: 8]}, {24'h0, iac_bus_peer_inst.seen[i]});
    end
    wr(`IAC_OFF_STAT, 32'hffff_ffff);
  endtask
  task automatic t_reset;
    rdchk("ctrl", `IAC_OFF_CTRL, 32'h0000_0020);
    rdchk("dest", `IAC_OFF_DEST, 32'h0000_0055);
    rdchk("own", `IAC_OFF_OWN, 32'h0000_0055);
    wr(`IAC_OFF_DEST, 32'hffff_ffff);
    rdchk("dest bits", `IAC_OFF_DEST, 32'h0000_1fff);
    apb(1'b0, 12'h0fc, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {31'h0, err});
  endtask
  task automatic t_own_lock;
    wr(`IAC_OFF_CTRL, 32'h0000_0021);
    wr(`IAC_OFF_OWN, 32'h0000_0033);
    rdchk("own locked", `IAC_OFF_OWN, 32'h0000_0055);
    wr(`IAC_OFF_CTRL, 32'h0000_0020);
    wr(`IAC_OFF_OWN, 32'h0000_0033);
    rdchk("own written", `IAC_OFF_OWN, 32'h0000_0033);
    wr(`IAC_OFF_OWN, 32'h0000_0255);
    wr(`IAC_OFF_CTRL, 32'h0000_0021);
  endtask
  task automatic t_master;
    m_frame(32'h0000_01ba, 1'b0, 1, 24'h74_0000);
    m_frame(32'h0000_01ba, 1'b1, 1, 24'h75_0000);
    m_frame(32'h0000_12a5, 1'b0, 2, 24'hf4_a500);
    m_frame(32'h0000_12a5, 1'b1, 3, 24'hf4_a5f5);
    m_frame(32'h0000_0255, 1'b0, 1, 24'haa_0000);
  endtask
  task automatic t_special;
    m_frame(32'h0000_0c3a, 1'b0, 1, 24'h01_0000);
    m_frame(32'h0000_083a, 1'b0, 1, 24'h00_0000);
    wr(`IAC_OFF_MASK, 32'h0000_0040);
    wr(`IAC_OFF_CMD, 32'h0000_0100);
    rdchk("read after broadcast", `IAC_OFF_STAT, 32'h0000_0040);
    @(negedge clk);
    chk("irq raised", 32'h0000_0001, {31'h0, irq});
    wr(`IAC_OFF_STAT, 32'h0000_0040);
    @(negedge clk);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    wr(`IAC_OFF_MASK, 32'h0000_0000);
    m_frame(32'h0000_083a, 1'b0, 1, 24'h00_0000);
    rdchk("broadcast mode", `IAC_OFF_STATE, 32'h0000_0002);
    m_frame(32'h0000_043a, 1'b0, 1, 24'h74_0000);
    rdchk("broadcast left", `IAC_OFF_STATE, 32'h0000_0000);
  endtask
  task automatic t_norestart;
    wr(`IAC_OFF_CTRL, 32'h0000_0001);
    wr(`IAC_OFF_DEST, 32'h0000_0c3a);
    wr(`IAC_OFF_CMD, 32'h0000_0000);
    rdchk("start byte refused", `IAC_OFF_STAT, 32'h0000_0040);
    wr(`IAC_OFF_STAT, 32'hffff_ffff);
    wr(`IAC_OFF_DEST, 32'h0000_12a5);
    wr(`IAC_OFF_CMD, 32'h0000_0100);
    rdchk("wide read refused", `IAC_OFF_STAT, 32'h0000_0040);
    wr(`IAC_OFF_STAT, 32'hffff_ffff);
    wr(`IAC_OFF_CTRL, 32'h0000_0021);
  endtask
  task automatic t_slave;
    iac_bus_peer_inst.xfer(1, 16'haa00, acks);
    chk("ack 7-bit write", 32'h0000_0000, {31'h0, acks[0]});
    rdchk("addressed write", `IAC_OFF_STAT, 32'h0000_0004);
    wr(`IAC_OFF_STAT, 32'hffff_ffff);
    iac_bus_peer_inst.xfer(1, 16'h2a00, acks);
    chk("no ack other", 32'h0000_0001, {31'h0, acks[0]});
    iac_bus_peer_inst.xfer(1, 16'hab00, acks);
    rdchk("addressed read", `IAC_OFF_STAT, 32'h0000_0020);
    wr(`IAC_OFF_CTRL, 32'h0000_0020);
    wr(`IAC_OFF_OWN, 32'h0000_0266);
    wr(`IAC_OFF_STAT, 32'hffff_ffff);
    wr(`IAC_OFF_CTRL, 32'h0000_0021);
    rdchk("read request again", `IAC_OFF_STAT, 32'h0000_0020);
    wr(`IAC_OFF_STAT, 32'hffff_ffff);
    wr(`IAC_OFF_CTRL, 32'h0000_0029);
    iac_bus_peer_inst.xfer(2, 16'hf466, acks);
    chk("ack 10-bit", 32'h0000_0000, {30'h0, acks});
    rdchk("wide write", `IAC_OFF_STAT, 32'h0000_0004);
    iac_bus_peer_inst.xfer(1, 16'hcc00, acks);
    chk("no 7-bit in wide", 32'h0000_0001, {31'h0, acks[0]});
  endtask
  // Clock
  initial begin
    clk = 1'b0;
    forever begin
      #4 clk = ~clk;
    end
  end
  // Main sequence
  initial begin
    req = '0;
    reset = 1'b1;
    errors = 0;
    n_compared = 0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_own_lock();
    t_master();
    t_special();
    t_norestart();
    t_slave();
    close_out();
  end
endmodule
